// *** rtl/tcc_pkg.sv ***
// Package of register map, field layout and encodings for the counter.
package tcc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int NUM_EVT = 5;
  localparam int SEL_W = 4;
  localparam int EDGE_W = 2;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CC = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CC_BUFF = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_TR_SEL = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_TR_EDGE = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h24;

  // Channel control fields.
  localparam int CTRL_SWAP_BIT = 0;
  localparam int CTRL_PRE_LSB = 8;
  localparam int CTRL_PRE_MSB = 15;
  localparam int CTRL_UD_LSB = 16;
  localparam int CTRL_UD_MSB = 17;
  localparam int CTRL_ONESHOT_BIT = 18;
  localparam int CTRL_MODE_LSB = 24;
  localparam int CTRL_MODE_MSB = 26;
  localparam logic [31:0] CTRL_WMASK = 32'h0707ff01;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;

  localparam logic [1:0] UD_UP = 2'h0;
  localparam logic [1:0] UD_DOWN = 2'h1;
  localparam logic [1:0] UD_BOTH0 = 2'h2;
  localparam logic [1:0] UD_BOTH1 = 2'h3;

  // Event indices, also the command register bit positions.
  localparam int EVT_CAPTURE = 0;
  localparam int EVT_RELOAD = 1;
  localparam int EVT_STOP = 2;
  localparam int EVT_START = 3;
  localparam int EVT_COUNT = 4;

  // Trigger source codes: 0 is constant low, 1 constant high, 2 on inputs.
  localparam logic [SEL_W-1:0] SRC_LOW = 4'h0;
  localparam logic [SEL_W-1:0] SRC_HIGH = 4'h1;
  localparam logic [SEL_W-1:0] SRC_FIRST = 4'h2;
  localparam logic [NUM_EVT*SEL_W-1:0] TR_SEL_RESET = 20'h10000;

  localparam logic [EDGE_W-1:0] EDGE_RISE = 2'h0;
  localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h1;
  localparam logic [EDGE_W-1:0] EDGE_BOTH = 2'h2;
  localparam logic [EDGE_W-1:0] EDGE_LEVEL = 2'h3;
  localparam logic [NUM_EVT*EDGE_W-1:0] TR_EDGE_RESET = 10'h3ff;

  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 16'hffff;
endpackage : tcc_pkg

// *** rtl/tcc_event_detect.sv ***
// One trigger event: source select, edge detect, parity fold, command merge.
`timescale 1ns/100ps
module tcc_event_detect #(
  parameter int NTRIG = 14
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic [tcc_pkg::SEL_W-1:0] sel_in,
  input wire logic [tcc_pkg::EDGE_W-1:0] edge_in,
  input wire logic [NTRIG-1:0] trig_in,
  input wire logic cmd_in,
  output logic evt_out
);
  import tcc_pkg::*;

  logic prev_q;
  logic par_q;
  logic pend_q;
  logic src;
  logic hit;
  logic [SEL_W-1:0] idx;

  assign idx = sel_in - SRC_FIRST;
  assign src = (sel_in == SRC_LOW) ? 1'b0 :
               (sel_in == SRC_HIGH) ? 1'b1 :
               (int'(idx) < NTRIG) ? trig_in[idx] : 1'b0;
  assign hit = (edge_in == EDGE_RISE) ? (src & ~prev_q) :
               (edge_in == EDGE_FALL) ? (~src & prev_q) :
               (edge_in == EDGE_BOTH) ? (src ^ prev_q) : 1'b0;
  // Edges within one counter clock cycle fold by parity.
  assign evt_out = ((edge_in == EDGE_LEVEL) ? src : (par_q ^ hit))
                   | cmd_in | pend_q;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prev_q <= 1'b0;
      par_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (ce_in) begin
      prev_q <= src;
      par_q <= tick_in ? 1'b0 : (par_q ^ hit);
      pend_q <= tick_in ? 1'b0 : (pend_q | cmd_in);
    end
  end
endmodule : tcc_event_detect

// *** rtl/tcc_counter.sv ***
// Timer and capture counter channel with its register file.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module tcc_counter #(
  parameter int NTRIG = 14
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic [tcc_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [tcc_pkg::DATA_W-1:0] WR_DATA_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [NTRIG-1:0] TRIG_IN,
  output logic [tcc_pkg::DATA_W-1:0] RD_DATA_OUT,
  output logic COMPARE_MATCH_OUT,
  output logic WRAP_HIGH_OUT,
  output logic WRAP_LOW_OUT,
  output logic TERMINAL_COUNT_OUT,
  output logic RUNNING_OUT
);
  import tcc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers and state.
  logic [31:0] ctrl_q;
  logic en_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] per_q;
  logic [CNT_W-1:0] cmp_q;
  logic [CNT_W-1:0] cbuf_q;
  logic [NUM_EVT*SEL_W-1:0] tsel_q;
  logic [NUM_EVT*EDGE_W-1:0] tedge_q;
  logic [7:0] pre_q;
  logic run_q;
  logic down_q;
  logic ov_hold_q;
  logic un_hold_q;
  logic [DATA_W-1:0] rd_q;
  logic cc_q;
  logic ovo_q;
  logic uno_q;
  logic tc_q;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and field views.
  logic wr_ctrl;
  logic wr_en;
  logic wr_cmd;
  logic wr_cnt;
  logic wr_per;
  logic wr_cmp;
  logic wr_cbuf;
  logic wr_tsel;
  logic wr_tedge;
  logic [2:0] mode;
  logic [1:0] ud;
  logic [7:0] pre_div;
  logic swap_en;
  logic one_shot;
  logic mode_cap;
  logic mode_ok;
  logic tick;
  logic tick_det;
  logic [NUM_EVT-1:0] cmd;
  logic [NUM_EVT-1:0] evt;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] status;

  assign wr_ctrl = WR_EN_IN && (ADDR_IN == ADDR_CTRL);
  assign wr_en = WR_EN_IN && (ADDR_IN == ADDR_ENABLE);
  assign wr_cmd = WR_EN_IN && (ADDR_IN == ADDR_CMD);
  assign wr_cnt = WR_EN_IN && (ADDR_IN == ADDR_COUNT);
  assign wr_per = WR_EN_IN && (ADDR_IN == ADDR_PERIOD);
  assign wr_cmp = WR_EN_IN && (ADDR_IN == ADDR_CC);
  assign wr_cbuf = WR_EN_IN && (ADDR_IN == ADDR_CC_BUFF);
  assign wr_tsel = WR_EN_IN && (ADDR_IN == ADDR_TR_SEL);
  assign wr_tedge = WR_EN_IN && (ADDR_IN == ADDR_TR_EDGE);

  assign mode = ctrl_q[CTRL_MODE_MSB:CTRL_MODE_LSB];
  assign ud = ctrl_q[CTRL_UD_MSB:CTRL_UD_LSB];
  assign pre_div = ctrl_q[CTRL_PRE_MSB:CTRL_PRE_LSB];
  assign swap_en = ctrl_q[CTRL_SWAP_BIT];
  assign one_shot = ctrl_q[CTRL_ONESHOT_BIT];
  assign mode_cap = (mode == MODE_CAPTURE);
  assign mode_ok = (mode == MODE_TIMER) || mode_cap;
  assign cmd = wr_cmd ? WR_DATA_IN[NUM_EVT-1:0] : '0;

  // The counter clock is the system clock divided by prescale plus one.
  assign tick = en_q && (pre_q == pre_div);
  // While disabled the detectors are flushed every cycle, so an edge or a
  // command seen then is not carried into the first tick after enabling.
  assign tick_det = tick || !en_q;

  assign status = {29'h0, down_q, run_q, en_q};
  assign rd_mux = (ADDR_IN == ADDR_CTRL) ? ctrl_q :
                  (ADDR_IN == ADDR_ENABLE) ? {31'h0, en_q} :
                  (ADDR_IN == ADDR_COUNT) ? {16'h0, cnt_q} :
                  (ADDR_IN == ADDR_PERIOD) ? {16'h0, per_q} :
                  (ADDR_IN == ADDR_CC) ? {16'h0, cmp_q} :
                  (ADDR_IN == ADDR_CC_BUFF) ? {16'h0, cbuf_q} :
                  (ADDR_IN == ADDR_TR_SEL) ? {12'h0, tsel_q} :
                  (ADDR_IN == ADDR_TR_EDGE) ? {22'h0, tedge_q} :
                  (ADDR_IN == ADDR_STATUS) ? status : 32'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Event detection, one detector per event.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++) begin : g_evt
      tcc_event_detect #(
        .NTRIG(NTRIG)
      ) u_det (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .ce_in(CE_IN),
        .tick_in(tick_det),
        .sel_in(tsel_q[gi*SEL_W +: SEL_W]),
        .edge_in(tedge_q[gi*EDGE_W +: EDGE_W]),
        .trig_in(TRIG_IN),
        .cmd_in(cmd[gi]),
        .evt_out(evt[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Count arithmetic, end decode and event views.
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] cnt_dec;
  logic [CNT_W-1:0] rel_val;
  logic rel_down;
  logic at_zero;
  logic at_top;
  logic ud_down;
  logic ev_start;
  logic ev_stop;
  logic ev_reload;

  assign cnt_inc = cnt_q + 16'h1;
  assign cnt_dec = cnt_q - 16'h1;
  assign rel_val = (ud == UD_DOWN) ? per_q : CNT_RESET;
  assign rel_down = (ud == UD_DOWN);
  assign at_zero = (cnt_q == CNT_RESET);
  assign at_top = (cnt_q >= per_q);
  // Up/down direction follows the count at its ends, so a direction left
  // over from another mode cannot run the count away from the period.
  assign ud_down = at_zero ? 1'b0 : (at_top ? 1'b1 : down_q);
  assign ev_start = evt[EVT_START];
  assign ev_stop = evt[EVT_STOP];
  assign ev_reload = evt[EVT_RELOAD];

  //////////////////////////////////////////////////////////////////////////////
  // Counting step.
  logic step;
  logic cap;
  logic [CNT_W-1:0] cnt_d;
  logic down_d;
  logic run_d;
  logic ov;
  logic un;
  logic tc;
  logic cmp_hit;

  assign step = tick && run_q && mode_ok && evt[EVT_COUNT];
  // Capture needs only an enabled channel, not a running one.
  assign cap = tick && mode_cap && evt[EVT_CAPTURE];

  always_comb begin
    cnt_d = cnt_q;
    down_d = down_q;
    run_d = run_q;
    ov = 1'b0;
    un = 1'b0;
    tc = 1'b0;
    if (!en_q) begin
      run_d = 1'b0;
    end else if (tick) begin
      if (ev_stop) begin
        run_d = 1'b0;
      end else if (ev_start || ev_reload) begin
        run_d = 1'b1;
      end
      if (ev_reload) begin
        cnt_d = rel_val;
        down_d = rel_down;
      end else if (step) begin
        case (ud)
          UD_UP: begin
            cnt_d = (cnt_q == per_q) ? CNT_RESET : cnt_inc;
            ov = (cnt_d == per_q);
            tc = ov;
            down_d = 1'b0;
          end
          UD_DOWN: begin
            cnt_d = at_zero ? per_q : cnt_dec;
            un = (cnt_d == CNT_RESET);
            tc = un;
            down_d = 1'b1;
          end
          default: begin
            down_d = ud_down;
            cnt_d = ud_down ? cnt_dec : cnt_inc;
            if (cnt_d == per_q) begin
              down_d = 1'b1;
              ov = 1'b1;
              tc = (ud == UD_BOTH1);
            end
            if (cnt_d == CNT_RESET) begin
              down_d = 1'b0;
              un = 1'b1;
              tc = 1'b1;
            end
          end
        endcase
        if (one_shot && ((ud == UD_UP) ? ov : un)) begin
          run_d = 1'b0;
        end
      end
    end
  end

  assign cmp_hit = step && !mode_cap && (cnt_d == cmp_q);

  //////////////////////////////////////////////////////////////////////////////
  // Software registers.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      ctrl_q <= CTRL_RESET;
      en_q <= 1'b0;
      per_q <= PERIOD_RESET;
      tsel_q <= TR_SEL_RESET;
      tedge_q <= TR_EDGE_RESET;
    end else if (CE_IN) begin
      if (wr_ctrl) begin
        ctrl_q <= WR_DATA_IN & CTRL_WMASK;
      end
      if (wr_en) begin
        en_q <= WR_DATA_IN[0];
      end
      if (wr_per) begin
        per_q <= WR_DATA_IN[CNT_W-1:0];
      end
      if (wr_tsel) begin
        tsel_q <= WR_DATA_IN[NUM_EVT*SEL_W-1:0];
      end
      if (wr_tedge) begin
        tedge_q <= WR_DATA_IN[NUM_EVT*EDGE_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare and capture registers.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      cmp_q <= CNT_RESET;
      cbuf_q <= CNT_RESET;
    end else if (CE_IN) begin
      if (cap) begin
        cmp_q <= cnt_q;
        cbuf_q <= cmp_q;
      end else if (cmp_hit && swap_en) begin
        cmp_q <= cbuf_q;
        cbuf_q <= cmp_q;
      end else begin
        if (wr_cmp) begin
          cmp_q <= WR_DATA_IN[CNT_W-1:0];
        end
        if (wr_cbuf) begin
          cbuf_q <= WR_DATA_IN[CNT_W-1:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter state, prescaler and outputs.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      cnt_q <= CNT_RESET;
      pre_q <= 8'h00;
      run_q <= 1'b0;
      down_q <= 1'b0;
    end else if (CE_IN) begin
      cnt_q <= wr_cnt ? WR_DATA_IN[CNT_W-1:0] : cnt_d;
      pre_q <= (!en_q || tick) ? 8'h00 : pre_q + 8'h01;
      run_q <= run_d;
      down_q <= down_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      ov_hold_q <= 1'b0;
      un_hold_q <= 1'b0;
      ovo_q <= 1'b0;
      uno_q <= 1'b0;
      tc_q <= 1'b0;
      cc_q <= 1'b0;
      rd_q <= 32'h0;
    end else if (CE_IN) begin
      ov_hold_q <= ov;
      un_hold_q <= un;
      ovo_q <= ov || ov_hold_q;
      uno_q <= un || un_hold_q;
      tc_q <= tc;
      cc_q <= cmp_hit || cap;
      rd_q <= RD_EN_IN ? rd_mux : 32'h0;
    end
  end

  assign RD_DATA_OUT = rd_q;
  assign COMPARE_MATCH_OUT = cc_q;
  assign WRAP_HIGH_OUT = ovo_q;
  assign WRAP_LOW_OUT = uno_q;
  assign TERMINAL_COUNT_OUT = tc_q;
  assign RUNNING_OUT = run_q;
endmodule : tcc_counter

// *** tb/tcc_counter_chk.sv ***
// Port checker of the counter channel, bound to its top module.
`timescale 1ns/100ps
module tcc_counter_chk import tcc_pkg::*; #(
  parameter int NTRIG = 14
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic [tcc_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [tcc_pkg::DATA_W-1:0] WR_DATA_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [NTRIG-1:0] TRIG_IN,
  input wire logic [tcc_pkg::DATA_W-1:0] RD_DATA_OUT,
  input wire logic COMPARE_MATCH_OUT,
  input wire logic WRAP_HIGH_OUT,
  input wire logic WRAP_LOW_OUT,
  input wire logic TERMINAL_COUNT_OUT,
  input wire logic RUNNING_OUT
);
  logic [1:0] ud_q;
  logic go_q;
  wire wr_take = CE_IN && WR_EN_IN;
  wire ctrl_wr = wr_take && ADDR_IN == ADDR_CTRL;
  wire en_wr = wr_take && ADDR_IN == ADDR_ENABLE;
  wire go_wr = wr_take && ADDR_IN == ADDR_CMD &&
    (WR_DATA_IN[EVT_START] || WR_DATA_IN[EVT_RELOAD]);
  // Shadows the direction field and whether a start or reload was commanded.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      ud_q <= UD_UP;
    end else if (ctrl_wr) begin
      ud_q <= WR_DATA_IN[CTRL_UD_MSB:CTRL_UD_LSB];
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || en_wr) begin
      go_q <= 1'b0;
    end else if (go_wr) begin
      go_q <= 1'b1;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  sequence s_stay_drop(sig);
    sig ##1 !sig;
  endsequence
  a_wrap_high_two: assert property (
    $rose(WRAP_HIGH_OUT) |=> s_stay_drop(WRAP_HIGH_OUT))
    else $error("overflow pulse length wrong");
  a_wrap_low_two: assert property (
    $rose(WRAP_LOW_OUT) |=> s_stay_drop(WRAP_LOW_OUT))
    else $error("underflow pulse length wrong");
  a_tc_single: assert property (
    TERMINAL_COUNT_OUT |=> !TERMINAL_COUNT_OUT)
    else $error("terminal count pulse too long");
  a_up_no_low: assert property (
    ud_q == UD_UP |-> !$rose(WRAP_LOW_OUT))
    else $error("underflow while counting up");
  a_up_tc_wrap: assert property (
    ud_q == UD_UP && $rose(WRAP_HIGH_OUT) |-> TERMINAL_COUNT_OUT)
    else $error("up count overflow without terminal count");
  a_down_tc_low: assert property (
    ud_q == UD_DOWN && $rose(WRAP_LOW_OUT) |-> TERMINAL_COUNT_OUT)
    else $error("down count underflow without terminal count");
  a_ud0_tc_top: assert property (
    ud_q == UD_BOTH0 && $rose(WRAP_HIGH_OUT) |-> !TERMINAL_COUNT_OUT)
    else $error("terminal count at top in mode 10");
  a_ud1_tc_top: assert property (
    ud_q == UD_BOTH1 && $rose(WRAP_HIGH_OUT) |-> TERMINAL_COUNT_OUT)
    else $error("no terminal count at top in mode 11");
  a_start_needed: assert property (
    $rose(RUNNING_OUT) |-> go_q)
    else $error("counter ran without a start");
endmodule : tcc_counter_chk

bind tcc_counter tcc_counter_chk #(.NTRIG(NTRIG)) u_chk (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN), .ADDR_IN(ADDR_IN),
  .WR_DATA_IN(WR_DATA_IN), .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN),
  .TRIG_IN(TRIG_IN), .RD_DATA_OUT(RD_DATA_OUT),
  .COMPARE_MATCH_OUT(COMPARE_MATCH_OUT), .WRAP_HIGH_OUT(WRAP_HIGH_OUT),
  .WRAP_LOW_OUT(WRAP_LOW_OUT), .TERMINAL_COUNT_OUT(TERMINAL_COUNT_OUT),
  .RUNNING_OUT(RUNNING_OUT));

// *** tb/tcc_counter_tb.sv ***
// Self-checking bench of the counter channel.
`timescale 1ns/100ps
module tcc_counter_tb;
  import tcc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wen = 1'b0;
  logic ren = 1'b0;
  logic ce = 1'b1;
  logic [13:0] trig = '0;
  logic [DATA_W-1:0] rdata, d, v, prev;
  logic cm, wh, wl, tc, run;
  int n_errors = 0;
  int total_checks = 0;
  int n_cm = 0;
  int cyc, p, pre, n0;
  localparam logic [ADDR_W-1:0] RA [11] = '{ADDR_CTRL, ADDR_ENABLE,
    ADDR_CMD, ADDR_COUNT, ADDR_PERIOD, ADDR_CC, ADDR_CC_BUFF, ADDR_TR_SEL,
    ADDR_TR_EDGE, ADDR_STATUS, 8'h40};
  localparam logic [DATA_W-1:0] RV [11] = '{CTRL_RESET, 32'h0, 32'h0,
    32'(CNT_RESET), 32'(PERIOD_RESET), 32'h0, 32'h0, 32'(TR_SEL_RESET),
    32'(TR_EDGE_RESET), 32'h0, 32'h0};
  tcc_counter #(.NTRIG(14)) DUT (
    .CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .ADDR_IN(addr),
    .WR_DATA_IN(wdata), .WR_EN_IN(wen), .RD_EN_IN(ren), .TRIG_IN(trig),
    .RD_DATA_OUT(rdata), .COMPARE_MATCH_OUT(cm), .WRAP_HIGH_OUT(wh),
    .WRAP_LOW_OUT(wl), .TERMINAL_COUNT_OUT(tc), .RUNNING_OUT(run));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cm === 1'b1) begin
      n_cm <= n_cm + 1;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wen <= 1'b1;
    @(posedge clk);
    wen <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clk);
    addr <= a;
    ren <= 1'b1;
    @(posedge clk);
    ren <= 1'b0;
    #1 x = rdata;
  endtask : rd
  function automatic logic pick(input int s);
    return s == 0 ? wh : (s == 1 ? wl : cm);
  endfunction : pick
  task automatic rise(input int s);
    logic pv;
    pv = 1'b1;
    for (int t = 0; t < 3000; t++) begin
      if (pick(s) === 1'b1 && pv !== 1'b1) begin
        return;
      end
      pv = pick(s);
      @(negedge clk);
      cyc++;
    end
    n_errors++;
    $display("mismatch at %0t: no rising edge seen", $time);
  endtask : rise
  task automatic span(input int s, input int e);
    rise(s);
    cyc = 0;
    rise(s);
    chk(32'(cyc), 32'(e));
  endtask : span
  function automatic int exp_span(input int u, input int pr, input int ps);
    return (u < 2 ? pr + 1 : 2 * pr) * (ps + 1);
  endfunction : exp_span
  function automatic logic [31:0] mk(input logic [2:0] m,
      input logic [1:0] u, input logic os, input logic [7:0] pr,
      input logic sw);
    logic [31:0] c;
    c = '0;
    c[CTRL_MODE_MSB:CTRL_MODE_LSB] = m;
    c[CTRL_ONESHOT_BIT] = os;
    c[CTRL_UD_MSB:CTRL_UD_LSB] = u;
    c[CTRL_PRE_MSB:CTRL_PRE_LSB] = pr;
    c[CTRL_SWAP_BIT] = sw;
    return c;
  endfunction : mk
  task automatic cfg(input logic [31:0] c, input logic [15:0] per,
      input logic [15:0] cc, input logic [15:0] cb);
    wr(ADDR_ENABLE, 32'h0);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, c);
    wr(ADDR_PERIOD, {16'h0, per});
    wr(ADDR_CC, {16'h0, cc});
    wr(ADDR_CC_BUFF, {16'h0, cb});
    wr(ADDR_TR_SEL, 32'h10002);
    wr(ADDR_TR_EDGE, {22'h0, 8'hff, EDGE_RISE});
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_CMD, 32'h8);
  endtask : cfg
  task automatic pulses(input int n);
    for (int k = 0; k < 2 * n; k++) begin
      @(posedge clk);
      trig[0] <= k[0];
    end
  endtask : pulses
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    test_done();
  end
  initial begin
    void'($urandom(18));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    trig[13:1] <= 13'($urandom);
    for (int i = 0; i < 11; i++) begin
      rd(RA[i], d);
      chk(d, RV[i]);
    end
    v = $urandom;
    wr(ADDR_CTRL, v);
    rd(ADDR_CTRL, d);
    chk(d, v & CTRL_WMASK);
    wr(ADDR_PERIOD, v);
    rd(ADDR_PERIOD, d);
    chk(d, {16'h0, v[15:0]});
    for (int u = 0; u < 4; u++) begin
      p = 3 + $urandom_range(5);
      pre = $urandom_range(2);
      cfg(mk(MODE_TIMER, 2'(u), 1'b0, 8'(pre), 1'b0), 16'(p), 16'h0, 16'h0);
      span(u == 1 ? 1 : 0, exp_span(u, p, pre));
    end
    wr(ADDR_ENABLE, 32'h0);
    rd(ADDR_COUNT, v);
    repeat (6) @(posedge clk);
    rd(ADDR_COUNT, d);
    chk(d, v);
    chk(32'(run), 32'h0);
    cfg(mk(MODE_TIMER, UD_UP, 1'b0, 8'h0, 1'b0), 16'h14, 16'h3, 16'hf);
    span(2, 21);
    cfg(mk(MODE_TIMER, UD_UP, 1'b0, 8'h0, 1'b1), 16'h14, 16'h3, 16'hf);
    rise(2);
    rd(ADDR_CC, d);
    chk(d, 32'hf);
    rd(ADDR_CC_BUFF, d);
    chk(d, 32'h3);
    cfg(mk(MODE_TIMER, UD_UP, 1'b1, 8'h0, 1'b0), 16'h5, 16'h0, 16'h0);
    repeat (20) @(posedge clk);
    chk(32'(run), 32'h0);
    rd(ADDR_COUNT, d);
    chk(d, 32'h5);
    cfg(mk(MODE_CAPTURE, UD_UP, 1'b0, 8'h0, 1'b0), 16'hffff, 16'h0, 16'h0);
    prev = 32'h0;
    for (int k = 0; k < 3; k++) begin
      repeat ($urandom_range(9)) @(posedge clk);
      n0 = n_cm;
      rd(ADDR_COUNT, v);
      wr(ADDR_CMD, 32'h1);
      rd(ADDR_CC, d);
      chk(d, v + 32'h2);
      rd(ADDR_CC_BUFF, d);
      chk(d, prev);
      prev = v + 32'h2;
      chk(32'(n_cm - n0), 32'h1);
    end
    rd(ADDR_COUNT, v);
    @(posedge clk);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    rd(ADDR_COUNT, d);
    chk(d, v + 32'h3);
    n0 = n_cm;
    pulses(1);
    repeat (6) @(posedge clk);
    trig[0] <= 1'b0;
    repeat (6) @(posedge clk);
    chk(32'(n_cm - n0), 32'h1);
    cfg(mk(MODE_CAPTURE, UD_UP, 1'b0, 8'hf, 1'b0), 16'hffff, 16'h0, 16'h0);
    @(posedge clk);
    trig[0] <= 1'b1;
    rise(2);
    n0 = n_cm;
    pulses(3);
    rise(2);
    pulses(2);
    repeat (40) @(posedge clk);
    // The aligning capture is counted as well.
    chk(32'(n_cm - n0), 32'h2);
    test_done();
  end
endmodule : tcc_counter_tb
